// file: adcfc_regs.sv
// adcfc_regs: function control bank of the converter with the sample
// output path it steers: divider, test patterns, offset trim, formatting.
// assumes: the serial port front end hands over decoded byte accesses;
// samples and user patterns come from logic on the same clock.
`timescale 1ns/100ps

// Function
// - power field: 00 normal, 01 full power-down, 10 standby, 11 reserved
// - divide-ratio field divides the input clock by value plus one
// - phase field delays the divided clock by that many input cycles
// - nonzero test field replaces samples with test data; 0000 normal
// - test 0001 midscale, 0010 positive full scale, 0011 negative
// - test 0101 long pseudorandom sequence; a bit resets that generator
// - test 0110 short pseudorandom sequence; a bit resets that generator
// - test 0111 toggles all ones and zeros; 0100 checkerboard words
// - test 1000 user patterns; top bit 0 repeats, 1 sends once then zeros
// - six-bit twos complement offset from +31 to -32 added to samples
// - output enable bar: 0 drives the outputs except in power-down or standby, 1 turns them off
// - format 00 offset binary, 01 twos complement, 10 Gray; resets 01
// - invert bit 0 passes data, 1 inverts every output bit
module adcfc_regs (
  // clock, reset, freeze
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // register access from the serial port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // converted samples, offset binary
  input wire logic [adcfc_pkg::DATA_W-1:0] ADC_DATA,
  input wire logic ADC_VALID,
  output logic ADC_READY,
  // user pattern words
  input wire adcfc_pkg::adcfc_user_t USER_PATTERN,
  // output port
  output logic [adcfc_pkg::DATA_W-1:0] DOUT,
  output logic DOUT_VALID,
  input wire logic DOUT_READY,
  output logic DOUT_OE,
  // status towards the core
  output logic SAMPLE_TICK,
  output logic DCS_ON,
  output logic POWER_DOWN,
  output logic STANDBY
);

  // saturating add of a signed trim to an offset binary code
  function automatic logic [adcfc_pkg::DATA_W-1:0] trim_add(
    input logic [adcfc_pkg::DATA_W-1:0] code,
    input logic [adcfc_pkg::OFFS_W-1:0] offs
  );
    logic signed [adcfc_pkg::DATA_W+1:0] sum;
    sum = $signed({2'b00, code}) +
          $signed({{(adcfc_pkg::DATA_W-adcfc_pkg::OFFS_W+2){offs[5]}}, offs});
    if (sum < 0) begin
      trim_add = '0;
    end else if (sum > $signed({2'b00, adcfc_pkg::CODE_MAX})) begin
      trim_add = adcfc_pkg::CODE_MAX;
    end else begin
      trim_add = sum[adcfc_pkg::DATA_W-1:0];
    end
  endfunction

  // recode an offset binary word into the selected format
  function automatic logic [adcfc_pkg::DATA_W-1:0] fmt_code(
    input logic [adcfc_pkg::DATA_W-1:0] code,
    input adcfc_pkg::adcfc_fmt_t fmt
  );
    case (fmt)
      adcfc_pkg::FMT_OFFSET_BIN: fmt_code = code;
      adcfc_pkg::FMT_TWOS: fmt_code = {~code[13], code[12:0]};
      adcfc_pkg::FMT_GRAY: fmt_code = code ^ (code >> 1);
      default: fmt_code = code;
    endcase
  endfunction

  // user pattern sequencer states
  typedef enum logic [2:0] {
    US_REPEAT = 3'b001,
    US_ONCE = 3'b010,
    US_DONE = 3'b100
  } adcfc_useq_t;

  // register storage
  logic [7:0] pwr_q, gclk_q, cdiv_q, test_q, offs_q, outf_q, rdata_q;

  // generator state
  logic [adcfc_pkg::LONG_W-1:0] long_q;
  logic [adcfc_pkg::SHORT_W-1:0] short_q;
  logic alt_q;
  logic [adcfc_pkg::DATA_W-1:0] ramp_q;
  logic [1:0] uidx_q;
  adcfc_useq_t useq_q;
  adcfc_useq_t useq_d;
  logic oe_q;

  // address decode
  wire logic wr_pwr = REG_WR && (REG_ADDR == adcfc_pkg::ADDR_PWR);
  wire logic wr_gclk = REG_WR && (REG_ADDR == adcfc_pkg::ADDR_GCLK);
  wire logic wr_cdiv = REG_WR && (REG_ADDR == adcfc_pkg::ADDR_CDIV);
  wire logic wr_test = REG_WR && (REG_ADDR == adcfc_pkg::ADDR_TEST);
  wire logic wr_offs = REG_WR && (REG_ADDR == adcfc_pkg::ADDR_OFFS);
  wire logic wr_outf = REG_WR && (REG_ADDR == adcfc_pkg::ADDR_OUTF);
  wire logic [7:0] rd_mux;

  // read mux; an unmapped address reads zero
  assign rd_mux =
    (REG_ADDR == adcfc_pkg::ADDR_PWR) ? pwr_q :
    (REG_ADDR == adcfc_pkg::ADDR_GCLK) ? gclk_q :
    (REG_ADDR == adcfc_pkg::ADDR_CDIV) ? cdiv_q :
    (REG_ADDR == adcfc_pkg::ADDR_TEST) ? test_q :
    (REG_ADDR == adcfc_pkg::ADDR_OFFS) ? offs_q :
    (REG_ADDR == adcfc_pkg::ADDR_OUTF) ? outf_q : adcfc_pkg::RD_NONE;

  // register writes; open bits are masked so they read back zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_q <= adcfc_pkg::RST_PWR;
      gclk_q <= adcfc_pkg::RST_GCLK;
      cdiv_q <= adcfc_pkg::RST_CDIV;
      test_q <= adcfc_pkg::RST_TEST;
      offs_q <= adcfc_pkg::RST_OFFS;
      outf_q <= adcfc_pkg::RST_OUTF;
    end else if (CE) begin
      if (wr_pwr) pwr_q <= REG_WDATA & adcfc_pkg::MASK_PWR;
      if (wr_gclk) gclk_q <= REG_WDATA & adcfc_pkg::MASK_GCLK;
      if (wr_cdiv) cdiv_q <= REG_WDATA & adcfc_pkg::MASK_CDIV;
      if (wr_test) test_q <= REG_WDATA & adcfc_pkg::MASK_TEST;
      if (wr_offs) offs_q <= REG_WDATA & adcfc_pkg::MASK_OFFS;
      if (wr_outf) outf_q <= REG_WDATA & adcfc_pkg::MASK_OUTF;
    end
  end

  // read data held until the next read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= adcfc_pkg::RD_NONE;
    end else if (CE && REG_RD) begin
      rdata_q <= rd_mux;
    end
  end
  assign REG_RDATA = rdata_q;

  // field views
  wire adcfc_pkg::adcfc_pwr_t pwr_mode =
    adcfc_pkg::adcfc_pwr_t'(pwr_q[adcfc_pkg::PWR_LSB +: 2]);
  wire adcfc_pkg::adcfc_test_t test_mode =
    adcfc_pkg::adcfc_test_t'(test_q[adcfc_pkg::MODE_LSB +: 4]);
  wire adcfc_pkg::adcfc_fmt_t fmt_sel =
    adcfc_pkg::adcfc_fmt_t'(outf_q[adcfc_pkg::FMT_LSB +: 2]);
  wire logic [adcfc_pkg::DIV_W-1:0] div_ratio =
    cdiv_q[adcfc_pkg::RATIO_LSB +: adcfc_pkg::DIV_W];
  wire logic [adcfc_pkg::DIV_W-1:0] div_phase =
    cdiv_q[adcfc_pkg::PHASE_LSB +: adcfc_pkg::DIV_W];
  wire logic [adcfc_pkg::OFFS_W-1:0] offs_val =
    offs_q[adcfc_pkg::OFFS_LSB +: adcfc_pkg::OFFS_W];
  wire logic run;
  wire logic invert = outf_q[adcfc_pkg::INV_BIT];
  wire logic out_en_n = outf_q[adcfc_pkg::OEB_BIT];
  wire logic long_hold = test_q[adcfc_pkg::RST_LONG_BIT];
  wire logic short_hold = test_q[adcfc_pkg::RST_SHORT_BIT];

  // power mode; the reserved code is run as normal operation
  assign POWER_DOWN = (pwr_mode == adcfc_pkg::PWR_DOWN);
  assign STANDBY = (pwr_mode == adcfc_pkg::PWR_STANDBY);
  assign run = !POWER_DOWN && !STANDBY;

  // stabiliser forced on by any real division
  assign DCS_ON = gclk_q[adcfc_pkg::DCS_BIT] || (div_ratio != '0);

  // sample clock divider
  wire logic tick;
  adcfc_clkdiv u_clkdiv (
    .clk (CLK),
    .rst_n (RST_N),
    .ce (CE),
    .ratio (div_ratio),
    .phase (div_phase),
    .tick (tick)
  );
  assign SAMPLE_TICK = tick;

  // handshake into the buffer; a full buffer stalls generators and samples
  wire logic buf_ready;
  wire logic test_on = (test_mode != adcfc_pkg::TM_OFF);
  wire logic slot = tick && run && buf_ready;
  wire logic push = slot && (test_on || ADC_VALID);
  wire logic adv = push && test_on && CE;
  assign ADC_READY = slot && !test_on;

  // long and short generators; each held reset bit parks its own generator at the seed
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      long_q <= adcfc_pkg::LONG_SEED;
      short_q <= adcfc_pkg::SHORT_SEED;
    end else if (CE) begin
      if (long_hold) begin
        long_q <= adcfc_pkg::LONG_SEED;
      end else if (adv && test_mode == adcfc_pkg::TM_PN_LONG) begin
        long_q <= {long_q[adcfc_pkg::LONG_W-2:0],
                   long_q[adcfc_pkg::LONG_W-1] ^
                   long_q[adcfc_pkg::LONG_TAP-1]};
      end
      if (short_hold) begin
        short_q <= adcfc_pkg::SHORT_SEED;
      end else if (adv && test_mode == adcfc_pkg::TM_PN_SHORT) begin
        short_q <= {short_q[adcfc_pkg::SHORT_W-2:0],
                    short_q[adcfc_pkg::SHORT_W-1] ^
                    short_q[adcfc_pkg::SHORT_TAP-1]};
      end
    end
  end

  // alternation phase and ramp; a test register write restarts both
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      alt_q <= 1'b0;
      ramp_q <= '0;
    end else if (CE) begin
      if (wr_test) begin
        alt_q <= 1'b0;
        ramp_q <= '0;
      end else if (adv) begin
        alt_q <= ~alt_q;
        ramp_q <= ramp_q + 14'h0001;
      end
    end
  end

  // user pattern sequencer: one-shot runs end after the last word
  wire logic user_step;
  wire logic user_last;
  assign user_step = adv && (test_mode == adcfc_pkg::TM_USER);
  assign user_last = (uidx_q == 2'(adcfc_pkg::USER_NUM - 1));

  always_comb begin
    useq_d = useq_q;
    case (useq_q)
      US_REPEAT: useq_d = US_REPEAT;
      US_ONCE: if (user_step && user_last) useq_d = US_DONE;
      US_DONE: useq_d = US_DONE;
      default: useq_d = US_REPEAT;
    endcase
    if (wr_test) begin
      useq_d = REG_WDATA[adcfc_pkg::USER_ONCE_BIT] ? US_ONCE : US_REPEAT;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      useq_q <= US_REPEAT;
      uidx_q <= 2'h0;
    end else if (CE) begin
      useq_q <= useq_d;
      if (wr_test) uidx_q <= 2'h0;
      else if (user_step) uidx_q <= uidx_q + 2'h1;
    end
  end

  // test word selection; codes are formatted, bit patterns go out raw
  logic [adcfc_pkg::DATA_W-1:0] pat_word;
  logic pat_is_code;
  always_comb begin
    pat_word = adcfc_pkg::PAT_ZEROS;
    pat_is_code = 1'b1;
    case (test_mode)
      adcfc_pkg::TM_MID: pat_word = adcfc_pkg::PAT_MID;
      adcfc_pkg::TM_POS_FS: pat_word = adcfc_pkg::PAT_FULL_SCALE_POS;
      adcfc_pkg::TM_NEG_FS: pat_word = adcfc_pkg::PAT_FULL_SCALE_NEG;
      adcfc_pkg::TM_CHECKER: begin
        pat_word = alt_q ? adcfc_pkg::PAT_CHECK_B : adcfc_pkg::PAT_CHECK_A;
        pat_is_code = 1'b0;
      end
      adcfc_pkg::TM_PN_LONG: begin
        pat_word = long_q[adcfc_pkg::DATA_W-1:0];
        pat_is_code = 1'b0;
      end
      adcfc_pkg::TM_PN_SHORT: begin
        pat_word = {5'h00, short_q};
        pat_is_code = 1'b0;
      end
      adcfc_pkg::TM_TOGGLE: begin
        pat_word = alt_q ? adcfc_pkg::PAT_ZEROS : adcfc_pkg::PAT_ONES;
        pat_is_code = 1'b0;
      end
      adcfc_pkg::TM_USER: begin
        pat_word = (useq_q == US_DONE) ? adcfc_pkg::PAT_ZEROS :
                   USER_PATTERN[uidx_q][adcfc_pkg::DATA_W-1:0];
        pat_is_code = 1'b0;
      end
      adcfc_pkg::TM_RAMP: pat_word = ramp_q;
      default: pat_word = adcfc_pkg::PAT_ZEROS; // unused codes emit code zero, formatted like the other codes
    endcase
  end

  // sample path: trim, format, invert; trim only touches real samples
  wire logic [adcfc_pkg::DATA_W-1:0] trimmed;
  wire logic [adcfc_pkg::DATA_W-1:0] pre_fmt;
  wire logic [adcfc_pkg::DATA_W-1:0] formatted;
  wire adcfc_pkg::adcfc_word_t buf_in;

  assign trimmed = trim_add(ADC_DATA, offs_val);
  assign pre_fmt = test_on ? pat_word : trimmed;
  assign formatted = (test_on && !pat_is_code) ? pre_fmt :
                     fmt_code(pre_fmt, fmt_sel);
  assign buf_in.code = invert ? ~formatted : formatted;

  // two-entry buffer in front of the output port
  adcfc_pkg::adcfc_word_t buf_out;
  adcfc_skid u_skid (
    .clk (CLK),
    .rst_n (RST_N),
    .ce (CE),
    .in_valid (push),
    .in_ready (buf_ready),
    .in_data (buf_in),
    .out_valid (DOUT_VALID),
    .out_ready (DOUT_READY),
    .out_data (buf_out)
  );
  assign DOUT = buf_out.code;

  // output drive; registered so a write never glitches the enable
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_q <= 1'b0;
    end else if (CE) begin
      oe_q <= !out_en_n && run;
    end
  end
  assign DOUT_OE = oe_q;

endmodule // adcfc_regs

// file: adcfc_pkg.sv
// adcfc_pkg: constants, field layouts and types of the converter function
// control bank.
// assumes: one 14-bit sample path, byte-wide registers at 8-bit addresses.
package adcfc_pkg;

  // sample word
  localparam int DATA_W = 14;
  localparam int USER_NUM = 4;
  localparam int USER_W = 16;

  // register addresses
  localparam logic [7:0] ADDR_PWR = 8'h08;
  localparam logic [7:0] ADDR_GCLK = 8'h09;
  localparam logic [7:0] ADDR_CDIV = 8'h0b;
  localparam logic [7:0] ADDR_TEST = 8'h0d;
  localparam logic [7:0] ADDR_OFFS = 8'h10;
  localparam logic [7:0] ADDR_OUTF = 8'h14;

  // reset values
  localparam logic [7:0] RST_PWR = 8'h00;
  localparam logic [7:0] RST_GCLK = 8'h01;
  localparam logic [7:0] RST_CDIV = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_OFFS = 8'h00;
  localparam logic [7:0] RST_OUTF = 8'h01;
  localparam logic [7:0] RD_NONE = 8'h00;

  // implemented bits of each register, open bits read zero
  localparam logic [7:0] MASK_PWR = 8'h03;
  localparam logic [7:0] MASK_GCLK = 8'h01;
  localparam logic [7:0] MASK_CDIV = 8'h3f;
  localparam logic [7:0] MASK_TEST = 8'hbf;
  localparam logic [7:0] MASK_OFFS = 8'h3f;
  localparam logic [7:0] MASK_OUTF = 8'h17;

  // field positions
  localparam int PWR_LSB = 0;
  localparam int DCS_BIT = 0;
  localparam int RATIO_LSB = 0;
  localparam int PHASE_LSB = 3;
  localparam int DIV_W = 3;
  localparam int MODE_LSB = 0;
  localparam int RST_SHORT_BIT = 4;
  localparam int RST_LONG_BIT = 5;
  localparam int USER_ONCE_BIT = 7;
  localparam int OFFS_LSB = 0;
  localparam int OFFS_W = 6;
  localparam int FMT_LSB = 0;
  localparam int INV_BIT = 2;
  localparam int OEB_BIT = 4;

  // power modes
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_DOWN = 2'h1,
    PWR_STANDBY = 2'h2,
    PWR_RSVD = 2'h3
  } adcfc_pwr_t;

  // output test modes
  typedef enum logic [3:0] {
    TM_OFF = 4'h0,
    TM_MID = 4'h1,
    TM_POS_FS = 4'h2,
    TM_NEG_FS = 4'h3,
    TM_CHECKER = 4'h4,
    TM_PN_LONG = 4'h5,
    TM_PN_SHORT = 4'h6,
    TM_TOGGLE = 4'h7,
    TM_USER = 4'h8,
    TM_RAMP = 4'hf
  } adcfc_test_t;

  // output formats
  typedef enum logic [1:0] {
    FMT_OFFSET_BIN = 2'h0,
    FMT_TWOS = 2'h1,
    FMT_GRAY = 2'h2
  } adcfc_fmt_t;

  // fixed pattern words, offset binary
  localparam logic [DATA_W-1:0] PAT_MID = 14'h2000;
  localparam logic [DATA_W-1:0] PAT_FULL_SCALE_POS = 14'h3fff;
  localparam logic [DATA_W-1:0] PAT_FULL_SCALE_NEG = 14'h0000;
  localparam logic [DATA_W-1:0] PAT_CHECK_A = 14'h2aaa;
  localparam logic [DATA_W-1:0] PAT_CHECK_B = 14'h1555;
  localparam logic [DATA_W-1:0] PAT_ONES = 14'h3fff;
  localparam logic [DATA_W-1:0] PAT_ZEROS = 14'h0000;
  localparam logic [DATA_W-1:0] CODE_MAX = 14'h3fff;

  // pseudorandom generators: x^23+x^18+1 and x^9+x^5+1
  localparam int LONG_W = 23;
  localparam int LONG_TAP = 18;
  localparam int SHORT_W = 9;
  localparam int SHORT_TAP = 5;
  localparam logic [LONG_W-1:0] LONG_SEED = 23'h7fffff;
  localparam logic [SHORT_W-1:0] SHORT_SEED = 9'h1ff;

  // buffered output word
  typedef struct packed {
    logic [DATA_W-1:0] code;
  } adcfc_word_t;

  // user pattern set, word 0 first
  typedef logic [USER_NUM-1:0][USER_W-1:0] adcfc_user_t;

endpackage

// file: adcfc_clkdiv.sv
// adcfc_clkdiv: divides the input clock into a one-cycle sample tick with
// a programmable ratio and phase delay.
// assumes: ratio and phase come from registers on the same clock.
`timescale 1ns/100ps
module adcfc_clkdiv (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // settings
  input wire logic [adcfc_pkg::DIV_W-1:0] ratio,
  input wire logic [adcfc_pkg::DIV_W-1:0] phase,
  // divided tick
  output logic tick
);

  logic [adcfc_pkg::DIV_W-1:0] cnt_q;
  logic [6:0] dly_q;
  wire logic raw_tick;
  wire logic [7:0] taps;

  // >= so a ratio lowered below the count still wraps at once
  assign raw_tick = (cnt_q >= ratio);
  assign taps = {dly_q, raw_tick};
  assign tick = taps[phase];

  // cycle counter and delay line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      dly_q <= '0;
    end else if (ce) begin
      cnt_q <= raw_tick ? '0 : cnt_q + 3'h1;
      dly_q <= {dly_q[5:0], raw_tick};
    end
  end

endmodule // adcfc_clkdiv

// file: adcfc_skid.sv
// adcfc_skid: two-entry buffer with valid and ready on both sides.
// assumes: the drain side may hold ready low for any number of cycles.
`timescale 1ns/100ps
module adcfc_skid (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire adcfc_pkg::adcfc_word_t in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output adcfc_pkg::adcfc_word_t out_data
);

  adcfc_pkg::adcfc_word_t mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  wire logic push;
  wire logic pop;

  // full and empty straight from the occupancy count
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;
  assign out_data = mem_q[rd_q];

  // storage and pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // adcfc_skid

// file: adcfc_regs_assertions.sv
// adcfc_regs_assertions: port-level checks of the function control bank.
// assumes: bound to adcfc_regs, one clock, RST_N async active low.
`timescale 1ns/100ps
module adcfc_regs_assertions (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // sample and output ports
  input wire logic ADC_VALID,
  input wire logic ADC_READY,
  input wire logic [adcfc_pkg::DATA_W-1:0] DOUT,
  input wire logic DOUT_VALID,
  input wire logic DOUT_READY,
  input wire logic DOUT_OE,
  // status
  input wire logic SAMPLE_TICK,
  input wire logic DCS_ON,
  input wire logic POWER_DOWN,
  input wire logic STANDBY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // a taken write, and a write read back two edges later
  sequence wr_to(logic [7:0] a);
    CE && REG_WR && REG_ADDR == a;
  endsequence
  sequence wr_rd(logic [7:0] a);
    wr_to(a) ##1 !(REG_WR && REG_ADDR == a) ##1
      (CE && REG_RD && !REG_WR && REG_ADDR == a);
  endsequence

  a_pwr_code_map: assert property (wr_to(8'h08) |=>
    POWER_DOWN == (($past(REG_WDATA) & 8'h03) == 8'h01) &&
    STANDBY == (($past(REG_WDATA) & 8'h03) == 8'h02))
    else $error("power status does not follow the written code");
  a_dcs_forced_on: assert property (
    wr_to(8'h0b) ##0 REG_WDATA[2:0] != 3'h0 |=> DCS_ON)
    else $error("stabiliser off with a divide ratio set");
  a_oe_bar_off: assert property (
    wr_to(8'h14) ##0 REG_WDATA[4] |-> ##2 !DOUT_OE)
    else $error("outputs still driven after enable bar set");
  a_test_refuses: assert property (
    wr_to(8'h0d) ##0 REG_WDATA[3:0] != 4'h0 |=> !ADC_READY)
    else $error("samples accepted while a test mode runs");
  a_ready_on_tick: assert property (
    ADC_READY |-> SAMPLE_TICK && !POWER_DOWN && !STANDBY)
    else $error("sample accepted off the divided tick");
  a_sample_lands: assert property (
    CE && ADC_VALID && ADC_READY |=> DOUT_VALID)
    else $error("taken sample did not reach the output");
  a_fmt_readback: assert property (wr_rd(8'h14) |=>
    REG_RDATA == ($past(REG_WDATA, 3) & 8'h17))
    else $error("output mode read back wrong");
  a_stall_holds: assert property ( // a stalled word must not change
    CE && DOUT_VALID && !DOUT_READY |=> DOUT_VALID && $stable(DOUT))
    else $error("output word lost or changed during stall");
endmodule // adcfc_regs_assertions

// file: adcfc_sink.sv
// adcfc_sink: stand-in for the logic behind the output port, paces ready.
// assumes: words pop on rising clk while valid and ready are high.
`timescale 1ns/100ps
module adcfc_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pacing: 0 always ready, 1 random stalls
  input wire logic slow,
  output logic ready
);
  logic [7:0] lfsr_q;
  // stall pattern moves on the falling edge, away from the pop edge
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= 8'h5a;
    end else begin
      lfsr_q <= {lfsr_q[6:0], ^(lfsr_q & 8'hb8)};
    end
  end
  assign ready = !slow || lfsr_q[0];
endmodule // adcfc_sink

// file: tb.sv
// tb: self-checking bench for the function control bank.
// assumes: bank, buffer and divider all run on one 200 MHz clock.
`timescale 1ns/100ps
module tb;
  logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic adc_valid = 1'h0, slow = 1'h1, ce = 1'h1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [13:0] adc_data = 14'h0000, dout;
  logic adc_ready, dout_valid, dout_ready, dout_oe, sample_tick;
  logic dcs_on, power_down, standby;
  adcfc_pkg::adcfc_user_t user = 64'h0;
  logic [31:0] seed = 32'hd419;
  logic [22:0] ls;
  logic [8:0] ss;
  logic [13:0] q[$], sq[$];
  int bad_count = 0, checks = 0;
  logic [7:0] ra [6] = '{8'h08, 8'h09, 8'h0b, 8'h0d, 8'h10, 8'h14};
  logic [7:0] rv [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] rm [6] = '{8'h03, 8'h01, 8'h3f, 8'hbf, 8'h3f, 8'h17};
  logic [7:0] md [13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h0f,
    8'h16, 8'h06, 8'h25, 8'h05, 8'h08, 8'h88, 8'h09};

  adcfc_regs dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .ADC_DATA(adc_data), .ADC_VALID(adc_valid),
    .ADC_READY(adc_ready), .USER_PATTERN(user), .DOUT(dout),
    .DOUT_VALID(dout_valid), .DOUT_READY(dout_ready), .DOUT_OE(dout_oe),
    .SAMPLE_TICK(sample_tick), .DCS_ON(dcs_on), .POWER_DOWN(power_down),
    .STANDBY(standby));
  adcfc_sink sink (.clk(clk), .rst_n(rst_n), .slow(slow),
    .ready(dout_ready));

  always #2.5 clk = ~clk;
  // new sample word each cycle, launched on the falling edge
  always @(negedge clk) adc_data <= 14'(rnd());
  // pre-edge values: popped words and taken samples, in order
  always @(posedge clk) begin
    if (ce && dout_valid && dout_ready) q.push_back(dout);
    if (ce && adc_valid && adc_ready) sq.push_back(adc_data);
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [13:0] fmt(logic [13:0] x, logic [1:0] f);
    return f == 2'h0 ? x : f == 2'h1 ? {~x[13], x[12:0]} : x ^ (x >> 1);
  endfunction
  // trims and clamps before formatting; the clamp mirrors the saturating trim
  function automatic logic [13:0] samp(logic [13:0] a, logic [5:0] o,
      logic [1:0] f, logic v);
    int s;
    s = int'(a) + int'($signed(o));
    s = s < 0 ? 0 : s > 16383 ? 16383 : s;
    return v ? ~fmt(14'(s), f) : fmt(14'(s), f);
  endfunction
  function automatic logic [13:0] pat(logic [7:0] m, int i);
    case (m[3:0])
      4'h1: return fmt(adcfc_pkg::PAT_MID, 2'h1);
      4'h2: return fmt(adcfc_pkg::PAT_FULL_SCALE_POS, 2'h1);
      4'h3: return fmt(adcfc_pkg::PAT_FULL_SCALE_NEG, 2'h1);
      4'h4: return i % 2 ? adcfc_pkg::PAT_CHECK_B : adcfc_pkg::PAT_CHECK_A;
      4'h7: return i % 2 ? adcfc_pkg::PAT_ZEROS : adcfc_pkg::PAT_ONES;
      4'h8: return (m[7] && i > 3) ? 14'h0000 : user[i % 4][13:0];
      4'hf: return fmt(14'(i), 2'h1);
      4'h5: return ls[13:0];
      4'h6: return {5'h00, ss};
      default: return fmt(14'h0000, 2'h1);
    endcase
  endfunction

  task automatic cmp(string n, logic [13:0] e, logic [13:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'h0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge clk);
    reg_rd = 1'h1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'h0;
    cmp("rdata", e, reg_rdata);
  endtask
  task automatic wait_words();
    for (int k = 0; k < 500 && q.size() < 8; k++) @(negedge clk);
  endtask
  // start a mode from standby so no stale word is counted
  task automatic run(logic [7:0] m);
    wr(8'h08, 8'h02);
    wr(8'h0d, m);
    repeat (16) @(negedge clk);
    q.delete();
    wr(8'h08, 8'h00);
    wait_words();
  endtask
  task automatic tick_gap(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (!sample_tick && c < 20);
  endtask
  task automatic end_sim();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end

  initial begin
    int i, c;
    logic [7:0] d;
    logic [5:0] o;
    logic [1:0] f;
    logic v;
    user = {rnd(), rnd()};
    repeat (4) @(negedge clk);
    rst_n = 1'h1;
    // reset values, masked write and read back, unmapped address
    for (i = 0; i < 6; i++) rd(ra[i], rv[i]);
    for (i = 0; i < 6; i++) begin
      d = 8'(rnd());
      wr(ra[i], d);
      rd(ra[i], d & rm[i]);
      wr(ra[i], rv[i]);
    end
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h00);
    // samples through trim, format and invert, both trim extremes
    for (i = 0; i < 5; i++) begin
      o = i == 0 ? 6'h1f : i == 1 ? 6'h20 : 6'(rnd());
      f = 2'(rnd() % 3);
      v = 1'(rnd());
      wr(8'h10, {2'h0, o});
      wr(8'h14, {5'h00, v, f});
      repeat (16) @(negedge clk);
      q.delete();
      sq.delete();
      adc_valid = 1'h1;
      wait_words();
      adc_valid = 1'h0;
      for (c = 0; c < 8; c++)
        cmp("sample", samp(sq[c], o, f, v), q[c]);
    end
    // a frozen bank must ignore a write
    ce = 1'h0;
    wr(8'h08, 8'h01);
    ce = 1'h1;
    cmp("freeze", 14'h0000, power_down);
    // power modes and output enable bar
    wr(8'h08, 8'h01);
    @(negedge clk);
    cmp("oe", 14'h0000, dout_oe);
    cmp("pd", 14'h0001, power_down);
    wr(8'h08, 8'h02);
    cmp("sb", 14'h0001, standby);
    wr(8'h08, 8'h00);
    wr(8'h14, 8'h11);
    @(negedge clk);
    cmp("oe", 14'h0000, dout_oe);
    wr(8'h14, 8'h01);
    @(negedge clk);
    cmp("oe", 14'h0001, dout_oe);
    // divide ratios with the stabiliser bit clear, then a phase step
    wr(8'h09, 8'h00);
    for (i = 0; i < 8; i++) begin
      wr(8'h0b, 8'(i));
      cmp("dcs", 14'(i != 0), dcs_on);
      tick_gap(c);
      tick_gap(c);
      cmp("period", 14'(i + 1), 14'(c));
    end
    wr(8'h0b, 8'h2f);
    tick_gap(c);
    cmp("phase", 14'h0005, 14'((c + 2) % 8));
    wr(8'h0b, 8'h00);
    wr(8'h09, 8'h01);
    // every defined test code and unused code 9, generator resets held then released
    ls = adcfc_pkg::LONG_SEED;
    ss = adcfc_pkg::SHORT_SEED;
    foreach (md[k]) begin
      run(md[k]);
      for (i = 0; i < 8; i++) begin
        cmp("pat", pat(md[k], i), q[i]);
        if (md[k] == 8'h05) ls = {ls[21:0], ls[22] ^ ls[17]};
        if (md[k] == 8'h06) ss = {ss[7:0], ss[8] ^ ss[4]};
      end
    end
    end_sim();
  end
endmodule // tb

bind adcfc_regs adcfc_regs_assertions chk (.CLK(CLK), .RST_N(RST_N),
  .CE(CE), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ADC_VALID(ADC_VALID),
  .ADC_READY(ADC_READY), .DOUT(DOUT), .DOUT_VALID(DOUT_VALID),
  .DOUT_READY(DOUT_READY), .DOUT_OE(DOUT_OE), .SAMPLE_TICK(SAMPLE_TICK),
  .DCS_ON(DCS_ON), .POWER_DOWN(POWER_DOWN), .STANDBY(STANDBY));
